//--- dv/sas_ana_model.sv
`timescale 1ns/1ps

module sas_ana_model (
  input wire logic clk,
  input sas_pkg::sas_ana_out_t ana_out,
  input wire logic [15:0][7:0] levels,
  output logic cmp_high
);
  import sas_pkg::*;

  // ------------------------------------------------------------
  // sample capacitor and comparator
  // ------------------------------------------------------------
  logic [7:0] held_reg;

  initial held_reg = 8'h00;

  // follows the routed input only while connected, keeps its charge between loads
  always @(posedge clk) begin
    if (ana_out.sample_en === 1'b1) begin
      held_reg <= levels[ana_out.input_select];
    end
  end

  assign cmp_high = (held_reg >= ana_out.trial_code);
endmodule // sas_ana_model

//--- dv/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import sas_pkg::*;

  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic clk;
  logic sys_rst;
  sas_bus_req_t bus_req;
  logic [7:0] rd_data;
  logic cmp_high;
  logic wait_mode;
  logic halt_mode;
  sas_ana_out_t ana_out;
  logic conv_active;
  logic irq;
  logic [15:0][7:0] levels;
  logic [7:0] rv;
  int fail_count;
  int n_tests;

  sas_adc_seq u_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .cmp_high(cmp_high),
    .wait_mode(wait_mode),
    .halt_mode(halt_mode),
    .ana_out(ana_out),
    .conv_active(conv_active),
    .irq(irq)
  );

  sas_ana_model u_ana (
    .clk(clk),
    .ana_out(ana_out),
    .levels(levels),
    .cmp_high(cmp_high)
  );

  always #5 clk = ~clk;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask

  // polls the control register, which leaves the completion flag alone
  task automatic wait_coco();
    logic [7:0] v;
    int i;
    for (i = 0; i < 40; i++) begin
      bus_rd(8'h71, v);
      if (v[7] === 1'b1) begin
        return;
      end
    end
    fail_count++;
    $display("unexpected timeout at %0t ns: got %h, expected %h", $time, v, 8'h80);
    complete_run();
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    bus_rd(8'h70, rv);
    chk(rv, 8'h00); // result clear
    bus_rd(8'h71, rv);
    chk(rv, 8'h00); // control clear
    chk({7'h00, conv_active}, 8'h00); // idle while off
  endtask

  task automatic t_channels();
    int n;
    for (n = 0; n < 16; n++) begin
      bus_wr(8'h71, {4'h2, n[3:0]}); // on, spare bits zero
      #1;
      chk({4'h0, ana_out.input_select}, {4'h0, n[3:0]}); // routed input
      wait_coco();
      bus_rd(8'h70, rv);
      chk(rv, levels[n]); // code of routed level
      bus_rd(8'h71, rv);
      chk(rv, {4'h2, n[3:0]}); // flag cleared by result read
    end
  endtask

  task automatic t_timing();
    logic [47:0] smp;
    logic [47:0] act;
    logic [7:0] first_trial;
    int i;
    bus_wr(8'h71, 8'h23);
    for (i = 0; i < 48; i++) begin
      #1;
      smp[i] = ana_out.sample_en;
      act[i] = conv_active;
      if (i == 8) begin
        first_trial = ana_out.trial_code;
      end
      @(posedge clk);
    end
    for (i = 0; i < 6; i++) begin
      chk(smp[i*8+:8], 8'(48'h0000_FF00_00FF >> (i * 8))); // load then approximation
      chk(act[i*8+:8], 8'hFF); // no idle gap
    end
    chk(first_trial, 8'h80); // top bit tried first
    wait_coco();
    bus_rd(8'h70, rv);
    chk(rv, 8'h33); // routed level
    levels[3] <= 8'hA5;
    bus_rd(8'h70, rv);
    chk(rv, 8'h33); // held until next end
    wait_coco();
    bus_rd(8'h70, rv);
    wait_coco();
    bus_rd(8'h70, rv);
    chk(rv, 8'hA5); // updated after completion
  endtask

  task automatic t_abort();
    int i;
    wait_coco();
    bus_wr(8'h71, 8'h23);
    #1;
    chk({7'h00, ana_out.sample_en}, 8'h01); // restart loads at once
    bus_rd(8'h71, rv);
    chk(rv, 8'h23); // flag dropped by write
    // rewrites closer than one conversion must keep it from ever ending
    for (i = 0; i < 8; i++) begin
      cycles(15);
      bus_wr(8'h71, 8'h23); // spare bits zero
    end
    bus_rd(8'h71, rv);
    chk(rv, 8'h23); // aborted before completion
    bus_rd(8'h72, rv);
    chk(rv, 8'h03); // abort and done events
  endtask

  task automatic t_events();
    logic seen;
    int i;
    chk({7'h00, irq}, 8'h00); // no interrupt by default
    bus_wr(8'h73, 8'h01);
    cycles(2);
    chk({7'h00, irq}, 8'h01); // unmasked done event
    bus_wr(8'h71, 8'h03); // converter off
    bus_wr(8'h72, 8'h03);
    cycles(2);
    chk({7'h00, irq}, 8'h00); // cleared event drops line
    seen = 1'b0;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      #1;
      seen = seen | conv_active;
    end
    chk({7'h00, seen}, 8'h00); // no conversion while off
    bus_rd(8'h72, rv);
    chk(rv, 8'h00); // no completion while off
    bus_rd(8'h74, rv);
    chk(rv, 8'h00); // unmapped reads zero
    bus_wr(8'h70, 8'h5A);
    bus_rd(8'h70, rv);
    chk(rv, 8'hA5); // result not writable
  endtask

  task automatic t_low_power();
    int i;
    wait_mode <= 1'b1;
    bus_wr(8'h71, 8'h2F); // converter back on
    wait_coco();
    bus_rd(8'h70, rv);
    chk(rv, 8'hFF); // full scale while cpu waits
    wait_mode <= 1'b0;
    halt_mode <= 1'b1;
    cycles(3);
    #1;
    chk({7'h00, conv_active}, 8'h00); // halted converter idle
    halt_mode <= 1'b0;
    i = 0;
    while (conv_active !== 1'b1 && i < 300) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk({7'h00, i > 90 && i < 300}, 8'h01); // settling before load
    if (i == 300) begin
      complete_run();
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    bus_req = '0;
    wait_mode = 1'b0;
    halt_mode = 1'b0;
    fail_count = 0;
    n_tests = 0;
    for (int n = 0; n < 16; n++) begin
      levels[n] = 8'(n * 17);
    end
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_channels();
    t_timing();
    t_abort();
    t_events();
    t_low_power();
    complete_run();
  end
endmodule // tb_top

//--- src/sas_adc_seq.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "sas_params.svh"

//Behaviour
// - input at or above high reference stores FFh, no overflow flag
// - input at or below low reference stores 00h
// - each conversion loads the capacitor, then eight approximation steps, input disconnected
// - while on, load and approximation repeat with no further trigger
// - one conversion lasts twelve converter clocks, converter clock is clk divided by two
// - four-bit input select in control bits 3:0 routes input N
// - setting converter on starts the first conversion, then runs continuously
// - completion flag set by hardware at each conversion end, no interrupt from it
// - result stays stable until the next conversion completes
// - control write while on aborts, clears completion flag, restarts
// - completion flag cleared by result read or control write
// - clearing converter on stops conversions, setting it resumes them
// - cpu wait mode leaves conversion untouched
// - halt disables converter, wake-up needs a stabilisation interval
// - control and result registers reset to zero
// - result register is read only, eight-bit unsigned 00h to FFh
module sas_adc_seq (
  input wire logic clk,
  input wire logic sys_rst,
  input sas_pkg::sas_bus_req_t bus_req,
  output logic [7:0] rd_data,
  input wire logic cmp_high,
  input wire logic wait_mode,
  input wire logic halt_mode,
  output sas_pkg::sas_ana_out_t ana_out,
  output logic conv_active,
  output logic irq
);
  import sas_pkg::*;

  sas_main_t main_reg;
  sas_main_t main_next;

  logic csr_wr;
  logic dr_rd;
  logic core_start;
  logic core_step;
  logic core_abort;
  logic core_done;
  logic [7:0] core_code;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
    addr_hit = (addr == off);
  endfunction

  function automatic logic [7:0] csr_image(input sas_main_t s);
    logic [7:0] v;
    v = `SAS_ZERO_BYTE;
    v[`SAS_CSR_COCO] = s.coco;
    v[`SAS_CSR_ON] = s.converter_on;
    v[`SAS_CSR_SEL_HI:`SAS_CSR_SEL_LO] = s.input_select;
    csr_image = v;
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign csr_wr = bus_req.wr && addr_hit(bus_req.addr, `SAS_OFF_CSR);
  assign dr_rd = bus_req.rd && addr_hit(bus_req.addr, `SAS_OFF_DR);

  // ----------------------------------------------------------------
  // sequencer strobes
  // ----------------------------------------------------------------
  // div high marks the second clk of each converter clock period
  // load ends after four periods
  assign core_start = (main_reg.st == SAS_ST_LOAD) && main_reg.div &&
                      (main_reg.cnt == `SAS_LOAD_LAST) && !csr_wr && !halt_mode;
  assign core_step = (main_reg.st == SAS_ST_APPROX) && main_reg.div && !csr_wr && !halt_mode;
  assign core_abort = csr_wr || halt_mode;

  sas_sar_core u_core (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(core_start),
    .step(core_step),
    .abort(core_abort),
    .cmp_high(cmp_high),
    .code(core_code),
    .done(core_done)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    main_next = main_reg;
    main_next.halt_d = halt_mode;
    main_next.rdata = `SAS_ZERO_BYTE;

    // wait mode is deliberately not an input to this logic
    // wait ignored
    case (main_reg.st)
      SAS_ST_OFF: begin
        if (main_reg.halt_d && !halt_mode && main_reg.converter_on) begin
          main_next.st = SAS_ST_SETTLE;
          main_next.stab = `SAS_ZERO_BYTE;
        end
      end
      SAS_ST_SETTLE: begin
        main_next.stab = main_reg.stab + 8'h01;
        if (main_reg.stab == 8'(`SAS_STAB_CYC - 1)) begin
          main_next.st = SAS_ST_LOAD;
          main_next.cnt = 4'h0;
          main_next.div = 1'b0;
        end
      end
      SAS_ST_LOAD: begin
        main_next.div = ~main_reg.div;
        if (main_reg.div) begin
          main_next.cnt = main_reg.cnt + 4'h1;
          if (main_reg.cnt == `SAS_LOAD_LAST) begin
            main_next.st = SAS_ST_APPROX;
          end
        end
      end
      SAS_ST_APPROX: begin
        main_next.div = ~main_reg.div;
        if (main_reg.div) begin
          if (main_reg.cnt == `SAS_APPROX_LAST) begin
            main_next.st = SAS_ST_LOAD;
            main_next.cnt = 4'h0;
          end else begin
            main_next.cnt = main_reg.cnt + 4'h1;
          end
        end
      end
      default: begin
        main_next.st = SAS_ST_OFF;
      end
    endcase

    // completion; a finished code is dropped if a control write aborts in the same cycle
    // clear on read
    if (dr_rd) begin
      main_next.coco = 1'b0;
    end
    if (core_done && !csr_wr) begin
      main_next.coco = 1'b1;
      main_next.result = core_code;
    end

    if (halt_mode) begin
      main_next.st = SAS_ST_OFF;
    end

    if (csr_wr) begin
      // reserved bits are not stored and read as zero
      main_next.input_select = bus_req.wdata[`SAS_CSR_SEL_HI:`SAS_CSR_SEL_LO];
      main_next.converter_on = bus_req.wdata[`SAS_CSR_ON];
      main_next.coco = 1'b0;
      if (!halt_mode && main_reg.st != SAS_ST_SETTLE) begin
        main_next.cnt = 4'h0;
        main_next.div = 1'b0;
        // on bit starts or stops conversions
        main_next.st = bus_req.wdata[`SAS_CSR_ON] ? SAS_ST_LOAD : SAS_ST_OFF;
      end else if (main_reg.st == SAS_ST_SETTLE && !bus_req.wdata[`SAS_CSR_ON]) begin
        main_next.st = SAS_ST_OFF;
      end
    end

    // ----------------------------------------------------------------
    // event status, mask and read mux
    // ----------------------------------------------------------------
    if (bus_req.wr && addr_hit(bus_req.addr, `SAS_OFF_EVT)) begin
      main_next.evt = main_reg.evt & ~bus_req.wdata[1:0];
    end
    if (bus_req.wr && addr_hit(bus_req.addr, `SAS_OFF_MASK)) begin
      main_next.mask = bus_req.wdata[1:0];
    end
    if (core_done && !csr_wr) begin
      main_next.evt[`SAS_EVT_DONE] = 1'b1;
    end
    if (csr_wr && (main_reg.st == SAS_ST_LOAD || main_reg.st == SAS_ST_APPROX)) begin
      main_next.evt[`SAS_EVT_ABORT] = 1'b1;
    end

    if (bus_req.rd) begin
      // result is read only; writes to it are ignored
      if (addr_hit(bus_req.addr, `SAS_OFF_DR)) begin
        main_next.rdata = main_reg.result;
      end else if (addr_hit(bus_req.addr, `SAS_OFF_CSR)) begin
        main_next.rdata = csr_image(main_reg);
      end else if (addr_hit(bus_req.addr, `SAS_OFF_EVT)) begin
        main_next.rdata = {6'h00, main_reg.evt};
      end else if (addr_hit(bus_req.addr, `SAS_OFF_MASK)) begin
        main_next.rdata = {6'h00, main_reg.mask};
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_reg <= '0;
    end else begin
      main_reg <= main_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_data = main_reg.rdata;
  assign ana_out.input_select = main_reg.input_select;
  assign ana_out.sample_en = (main_reg.st == SAS_ST_LOAD);
  assign ana_out.trial_code = core_code;
  assign conv_active = (main_reg.st == SAS_ST_LOAD) || (main_reg.st == SAS_ST_APPROX);
  // the completion flag itself is not an interrupt source; only the done and abort event bits are, and only unmasked
  assign irq = |(main_reg.evt & main_reg.mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_dr_read_data: assert property (dr_rd |=> rd_data == $past(main_reg.result))
    else $error("result read returned wrong data");
  a_coco_write_clear: assert property (csr_wr |=> !main_reg.coco)
    else $error("control write left completion flag set");
  a_coco_done_set: assert property (core_done && !csr_wr |=> main_reg.coco && main_reg.result == $past(core_code))
    else $error("completion not flagged with new result");
  a_coco_read_race: assert property (core_done && dr_rd && !csr_wr |=> main_reg.coco)
    else $error("read clear beat completion set");
  a_result_held: assert property (!core_done |=> $stable(main_reg.result))
    else $error("result changed without a completed conversion");
  a_sample_disconnect: assert property (main_reg.st == SAS_ST_APPROX |-> !ana_out.sample_en)
    else $error("sample path connected during approximation");
  a_conv_period: assert property (main_reg.st == SAS_ST_LOAD && $past(main_reg.st) == SAS_ST_APPROX
    && !$past(csr_wr) && !$past(halt_mode) |-> $past(core_start, 17))
    else $error("conversion not twenty four clk cycles long");
  a_load_length: assert property (core_start |-> $past(main_reg.st, 7) == SAS_ST_LOAD
    && $past(main_reg.cnt, 7) == 4'h0)
    else $error("load phase not four converter clocks");
  a_off_idle: assert property (!main_reg.converter_on |-> main_reg.st == SAS_ST_OFF)
    else $error("converter running while switched off");
  a_on_start: assert property (csr_wr && bus_req.wdata[`SAS_CSR_ON] && !halt_mode
    && main_reg.st != SAS_ST_SETTLE |=> main_reg.st == SAS_ST_LOAD ##8 main_reg.st == SAS_ST_APPROX)
    else $error("switching on did not start a conversion");
  a_halt_stop: assert property (halt_mode |=> main_reg.st == SAS_ST_OFF)
    else $error("converter active during halt");
  a_wait_ignored: assert property (wait_mode && main_reg.st == SAS_ST_APPROX && !csr_wr && !halt_mode
    |=> main_reg.st inside {SAS_ST_APPROX, SAS_ST_LOAD})
    else $error("wait mode disturbed conversion");
  a_reset_zero: assert property ($past(sys_rst) |-> main_reg.result == `SAS_ZERO_BYTE
    && csr_image(main_reg) == `SAS_ZERO_BYTE)
    else $error("registers not zero after reset");

  c_full_conv: cover property (core_start ##[16:20] core_done);
  c_abort: cover property (main_reg.st == SAS_ST_APPROX && csr_wr);
  c_read_race: cover property (core_done && dr_rd);
  c_halt_wake: cover property (main_reg.st == SAS_ST_SETTLE ##1 main_reg.st == SAS_ST_SETTLE);

endmodule // sas_adc_seq

//--- src/sas_params.svh
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SAS_ADDR_W 8
`define SAS_OFF_DR 8'h70
`define SAS_OFF_CSR 8'h71
`define SAS_OFF_EVT 8'h72
`define SAS_OFF_MASK 8'h73

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define SAS_CSR_COCO 7
`define SAS_CSR_ON 5
`define SAS_CSR_SEL_HI 3
`define SAS_CSR_SEL_LO 0
`define SAS_EVT_DONE 0
`define SAS_EVT_ABORT 1
`define SAS_ZERO_BYTE 8'h00
`define SAS_FULL_CODE 8'hFF
`define SAS_MID_CODE 8'h80
`define SAS_TOP_BIT 3'h7
`define SAS_LAST_BIT 3'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
// converter clock periods, counted 0..11 within one conversion
`define SAS_LOAD_LAST 4'h3
`define SAS_APPROX_LAST 4'hB
`define SAS_CLK_NS 10
`define SAS_STAB_NS 1000
`define SAS_STAB_CYC ((`SAS_STAB_NS + `SAS_CLK_NS - 1) / `SAS_CLK_NS)

`endif

//--- src/sas_pkg.sv
package sas_pkg;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sas_bus_req_t;

  typedef struct packed {
    logic [3:0] input_select;
    logic sample_en;
    logic [7:0] trial_code;
  } sas_ana_out_t;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SAS_ST_OFF,
    SAS_ST_SETTLE,
    SAS_ST_LOAD,
    SAS_ST_APPROX
  } sas_phase_t;

  typedef struct packed {
    logic [7:0] code;
    logic [2:0] idx;
    logic busy;
    logic done;
  } sas_core_t;

  typedef struct packed {
    sas_phase_t st;
    logic div;
    logic [3:0] cnt;
    logic converter_on;
    logic [3:0] input_select;
    logic coco;
    logic [7:0] result;
    logic [7:0] rdata;
    logic [1:0] evt;
    logic [1:0] mask;
    logic [7:0] stab;
    logic halt_d;
  } sas_main_t;

endpackage

//--- src/sas_sar_core.sv
`timescale 1ns/1ps
`include "sas_params.svh"

module sas_sar_core (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic step,
  input wire logic abort,
  input wire logic cmp_high,
  output logic [7:0] code,
  output logic done
);
  import sas_pkg::*;

  sas_core_t core_reg;
  sas_core_t core_next;

  // ----------------------------------------------------------------
  // successive approximation
  // ----------------------------------------------------------------
  always_comb begin
    core_next = core_reg;
    core_next.done = 1'b0;
    if (abort) begin
      core_next.busy = 1'b0;
    end else if (start) begin
      core_next.code = `SAS_MID_CODE;
      core_next.idx = `SAS_TOP_BIT;
      core_next.busy = 1'b1;
    end else if (step && core_reg.busy) begin
      // clamp at rails
      // comparator high means input sits at or above the trial level
      if (!cmp_high) begin
        core_next.code[core_reg.idx] = 1'b0;
      end
      if (core_reg.idx == `SAS_LAST_BIT) begin
        core_next.busy = 1'b0;
        core_next.done = 1'b1;
      end else begin
        core_next.code[core_reg.idx - 3'h1] = 1'b1;
        core_next.idx = core_reg.idx - 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_reg <= '0;
    end else begin
      core_reg <= core_next;
    end
  end

  assign code = core_reg.code;
  assign done = core_reg.done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic all_high;
  logic all_low;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      all_high <= 1'b0;
      all_low <= 1'b0;
    end else if (start) begin
      all_high <= 1'b1;
      all_low <= 1'b1;
    end else if (step && core_reg.busy) begin
      all_high <= all_high & cmp_high;
      all_low <= all_low & !cmp_high;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_full_scale_code: assert property (done && all_high |-> code == `SAS_FULL_CODE)
    else $error("input above high reference did not give full scale");
  a_zero_scale_code: assert property (done && all_low |-> code == `SAS_ZERO_BYTE)
    else $error("input below low reference did not give zero");
  a_done_after_step: assert property (done |-> $past(step) && $past(core_reg.idx) == `SAS_LAST_BIT)
    else $error("done without eighth approximation step");

endmodule // sas_sar_core
